// ==== hofc_pkg.sv ====
// hofc_pkg: constants shared by the hall output filter and clamp block
// assumes a 250 MHz core clock and 12-bit unsigned output codes
package hofc_pkg;
    localparam int unsigned CLK_HZ       = 250_000_000;
    localparam int unsigned LP_RATE_HZ   = 16_000;
    localparam int unsigned OUT_RATE_HZ  = 256_000;
    localparam int unsigned LP_DIV       = CLK_HZ / LP_RATE_HZ;
    localparam int unsigned OUT_DIV      = CLK_HZ / OUT_RATE_HZ;
    localparam int unsigned INTERP_STEPS = OUT_RATE_HZ / LP_RATE_HZ;

    localparam int          ADC_W  = 16;
    localparam int          CODE_W = 12;
    localparam int          ACC_W  = 24;

    // register byte offsets
    localparam logic [7:0]  OFS_BW_SEL  = 8'h00;
    localparam logic [7:0]  OFS_CLAMP_LO = 8'h04;
    localparam logic [7:0]  OFS_CLAMP_HI = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0C;
    localparam logic [7:0]  OFS_ECC_CTRL = 8'h10;

    // reset values
    localparam logic [2:0]  RST_BW_SEL   = 3'h7;
    localparam logic [11:0] RST_CLAMP_LO = 12'h000;
    localparam logic [11:0] RST_CLAMP_HI = 12'hFFF;

    // error output codes: full scale, and supply-fault levels (0.95 / 0.97)
    localparam logic [11:0] CODE_FULL   = 12'hFFF;
    localparam logic [11:0] CODE_UV     = 12'hF34;
    localparam logic [11:0] CODE_OV     = 12'hF86;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        HOFC_ECC_IDLE  = 2'b00,
        HOFC_ECC_ONE   = 2'b01,
        HOFC_ECC_FATAL = 2'b10
    } hofc_ecc_t;
endpackage

// ==== hofc_lowpass.sv ====
// hofc_lowpass: first-order unity-dc-gain low pass with selectable shift
// assumes samples arrive on a one-cycle strobe from the owning block
module hofc_lowpass
    import hofc_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    // sample stream
    input  wire logic              sample_en_i,
    input  wire logic [ADC_W-1:0]  sample_i,
    input  wire logic [2:0]        bw_sel_i,
    output logic      [ADC_W-1:0]  filt_o
);
    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] in_ext;
    logic [ACC_W:0]   delta;
    logic [ACC_W:0]   step;
    logic [3:0]       shift;

    // smaller shift means a wider cutoff; code 0 is the narrowest
    function automatic logic [3:0] bw_shift(input logic [2:0] sel);
        unique case (sel)
            3'd0:    bw_shift = 4'd7;
            3'd1:    bw_shift = 4'd6;
            3'd2:    bw_shift = 4'd5;
            3'd3:    bw_shift = 4'd4;
            3'd4:    bw_shift = 4'd3;
            3'd5:    bw_shift = 4'd2;
            3'd6:    bw_shift = 4'd1;
            default: bw_shift = 4'd0;
        endcase
    endfunction

    assign shift  = bw_shift(bw_sel_i);
    assign in_ext = {sample_i, 8'h00};
    // one spare bit keeps the difference signed over the full input range
    assign delta  = {1'b0, in_ext} - {1'b0, acc_ff};

    // settle exactly on input
    // a positive remainder below one step still moves by one lsb
    always_comb begin
        step = $signed(delta) >>> shift;
        if (!delta[ACC_W] && (delta != '0) && (step == '0)) begin
            step = {{ACC_W{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            acc_ff <= '0;
        end else if (sample_en_i) begin
            if (bw_sel_i == 3'd7) begin
                acc_ff <= in_ext;
            end else begin
                acc_ff <= acc_ff + step[ACC_W-1:0];
            end
        end
    end

    assign filt_o = acc_ff[ACC_W-1:8];
endmodule

// ==== hofc_top.sv ====
// hofc_top: input low pass, interpolation, limiter, clamp and error override
// assumes an axi4-lite master on the same clock and raw adc and dsp words
module hofc_top
    import hofc_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    // axi4-lite write address
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [7:0]        S_AXI_AWADDR_I,
    // axi4-lite write data
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    // axi4-lite write response
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    output logic [1:0]             S_AXI_BRESP_O,
    // axi4-lite read
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    input  wire logic [7:0]        S_AXI_ARADDR_I,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    // hall converter and dsp datapath
    input  wire logic [ADC_W-1:0]  HALL_ADC_I,
    output logic [ADC_W-1:0]       DSP_IN_O,
    output logic                   DSP_IN_STB_O,
    input  wire logic signed [15:0] DSP_RESULT_I,
    // fault sources
    input  wire logic              EE_LINE_ERR_I,
    input  wire logic              EE_SCAN_DONE_I,
    input  wire logic              SUPPLY_UV_I,
    input  wire logic              SUPPLY_OV_I,
    // dac
    output logic [CODE_W-1:0]      DAC_CODE_O,
    output logic                   DAC_STB_O
);
    // strobe dividers
    logic [15:0]       lp_cnt_ff;
    logic [15:0]       out_cnt_ff;
    logic              lp_en;
    logic              out_en;
    // registers
    logic [2:0]        bw_sel_ff;
    logic [11:0]       clamp_lo_ff;
    logic [11:0]       clamp_hi_ff;
    // datapath
    logic [ADC_W-1:0]  filt;
    logic signed [16:0] interp_ff;
    logic signed [16:0] step_ff;
    logic signed [16:0] dsp_target;
    logic [11:0]       limited;
    logic [11:0]       clamped;
    logic [11:0]       nxt_code;
    // fault sync and ecc tracking
    logic [2:0]        uv_sync_ff;
    logic [2:0]        ov_sync_ff;
    logic [2:0]        lerr_sync_ff;
    logic [2:0]        sdone_sync_ff;
    logic              uv_ff;
    logic              ov_ff;
    logic              lerr_ff;
    logic              sdone_ff;
    logic              lerr_d_ff;
    hofc_ecc_t         ecc_ff;
    logic              ecc_corr_ff;
    // bus
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [7:0]        aw_addr_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;

    // 16 kHz and 256 kHz strobes from the one clock
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            lp_cnt_ff  <= '0;
            out_cnt_ff <= '0;
        end else begin
            lp_cnt_ff  <= lp_en  ? 16'h0000 : lp_cnt_ff + 16'h0001;
            out_cnt_ff <= out_en ? 16'h0000 : out_cnt_ff + 16'h0001;
        end
    end
    assign lp_en  = (lp_cnt_ff == 16'(LP_DIV - 1));
    assign out_en = (out_cnt_ff == 16'(OUT_DIV - 1));

    hofc_lowpass u_lowpass (
        .CLK_I       (CLK_I),
        .RSTN_I      (RSTN_I),
        .sample_en_i (lp_en),
        .sample_i    (HALL_ADC_I),
        .bw_sel_i    (bw_sel_ff),
        .filt_o      (filt)
    );

    // new dsp sample each 16 kHz strobe
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            DSP_IN_O     <= '0;
            DSP_IN_STB_O <= 1'b0;
        end else begin
            DSP_IN_STB_O <= lp_en;
            if (lp_en) begin
                DSP_IN_O <= filt;
            end
        end
    end

    // dsp result scaled to 12-bit code units
    assign dsp_target = 17'($signed(DSP_RESULT_I) >>> 4);

    // linear ramp in sixteen steps per dsp result
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            interp_ff <= '0;
            step_ff   <= '0;
        end else if (lp_en) begin
            step_ff <= (dsp_target - interp_ff) >>> 4;
        end else if (out_en) begin
            interp_ff <= interp_ff + step_ff;
        end
    end

    assign limited = interp_ff[16] ? 12'h000 :
                     (interp_ff > 17'sd4095) ? 12'hFFF : interp_ff[11:0];

    // clamp on dac scale; high checked last wins
    always_comb begin
        clamped = limited;
        if (limited < clamp_lo_ff) begin
            clamped = clamp_lo_ff;
        end
        if (clamped > clamp_hi_ff || clamp_lo_ff > clamp_hi_ff) begin
            clamped = clamp_hi_ff;
        end
    end

    always_comb begin
        nxt_code = clamped;
        if (ecc_ff == HOFC_ECC_FATAL) begin
            nxt_code = CODE_FULL;
        end else if (ov_ff) begin
            nxt_code = CODE_OV;
        end else if (uv_ff) begin
            nxt_code = CODE_UV;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            DAC_CODE_O <= CODE_FULL;
            DAC_STB_O  <= 1'b0;
        end else begin
            DAC_STB_O <= out_en;
            if (out_en) begin
                DAC_CODE_O <= nxt_code;
            end
        end
    end

    // fault inputs cross in through three flops; change taken when 2nd and 3rd agree
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            uv_sync_ff    <= '0;
            ov_sync_ff    <= '0;
            lerr_sync_ff  <= '0;
            sdone_sync_ff <= '0;
            uv_ff         <= 1'b0;
            ov_ff         <= 1'b0;
            lerr_ff       <= 1'b0;
            sdone_ff      <= 1'b0;
        end else begin
            uv_sync_ff    <= {uv_sync_ff[1:0], SUPPLY_UV_I};
            ov_sync_ff    <= {ov_sync_ff[1:0], SUPPLY_OV_I};
            lerr_sync_ff  <= {lerr_sync_ff[1:0], EE_LINE_ERR_I};
            sdone_sync_ff <= {sdone_sync_ff[1:0], EE_SCAN_DONE_I};
            if (uv_sync_ff[1] == uv_sync_ff[2]) begin
                uv_ff <= uv_sync_ff[2];
            end
            if (ov_sync_ff[1] == ov_sync_ff[2]) begin
                ov_ff <= ov_sync_ff[2];
            end
            if (lerr_sync_ff[1] == lerr_sync_ff[2]) begin
                lerr_ff <= lerr_sync_ff[2];
            end
            if (sdone_sync_ff[1] == sdone_sync_ff[2]) begin
                sdone_ff <= sdone_sync_ff[2];
            end
        end
    end

    // each rising line-error level marks one faulty line in the current scan
    // first line corrected; second line is fatal
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            lerr_d_ff   <= 1'b0;
            ecc_ff      <= HOFC_ECC_IDLE;
            ecc_corr_ff <= 1'b0;
        end else begin
            lerr_d_ff <= lerr_ff;
            unique case (ecc_ff)
                HOFC_ECC_IDLE: begin
                    if (lerr_ff && !lerr_d_ff) begin
                        ecc_ff      <= HOFC_ECC_ONE;
                        ecc_corr_ff <= 1'b1;
                    end
                end
                HOFC_ECC_ONE: begin
                    if (lerr_ff && !lerr_d_ff) begin
                        ecc_ff <= HOFC_ECC_FATAL;
                    end else if (sdone_ff) begin
                        ecc_ff <= HOFC_ECC_IDLE;
                    end
                end
                HOFC_ECC_FATAL: begin
                    ecc_ff <= HOFC_ECC_FATAL;
                end
                default: begin
                    ecc_ff <= HOFC_ECC_FATAL;
                end
            endcase
        end
    end

    // axi4-lite write: address and data taken in either order
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            aw_held_ff      <= 1'b0;
            w_held_ff       <= 1'b0;
            aw_addr_ff      <= '0;
            w_data_ff       <= '0;
            w_strb_ff       <= '0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY_O <= !aw_held_ff && !S_AXI_AWREADY_O && !S_AXI_BVALID_O
                               && S_AXI_AWVALID_I;
            S_AXI_WREADY_O  <= !w_held_ff && !S_AXI_WREADY_O && !S_AXI_BVALID_O
                               && S_AXI_WVALID_I;
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held_ff <= 1'b1;
                w_data_ff <= S_AXI_WDATA_I;
                w_strb_ff <= S_AXI_WSTRB_I;
            end
            if (aw_held_ff && w_held_ff && !S_AXI_BVALID_O) begin
                aw_held_ff     <= 1'b0;
                w_held_ff      <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= (aw_addr_ff == OFS_BW_SEL || aw_addr_ff == OFS_CLAMP_LO
                                   || aw_addr_ff == OFS_CLAMP_HI) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            bw_sel_ff   <= RST_BW_SEL;
            clamp_lo_ff <= RST_CLAMP_LO;
            clamp_hi_ff <= RST_CLAMP_HI;
        end else if (aw_held_ff && w_held_ff && !S_AXI_BVALID_O) begin
            if (aw_addr_ff == OFS_BW_SEL && w_strb_ff[0]) begin
                bw_sel_ff <= w_data_ff[2:0];
            end
            if (aw_addr_ff == OFS_CLAMP_LO) begin
                if (w_strb_ff[0]) clamp_lo_ff[7:0]  <= w_data_ff[7:0];
                if (w_strb_ff[1]) clamp_lo_ff[11:8] <= w_data_ff[11:8];
            end
            if (aw_addr_ff == OFS_CLAMP_HI) begin
                if (w_strb_ff[0]) clamp_hi_ff[7:0]  <= w_data_ff[7:0];
                if (w_strb_ff[1]) clamp_hi_ff[11:8] <= w_data_ff[11:8];
            end
        end
    end

    // axi4-lite read: one-cycle ready, data the cycle after
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= '0;
            S_AXI_RRESP_O   <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O  <= RESP_OKAY;
                unique case (S_AXI_ARADDR_I)
                    OFS_BW_SEL:   S_AXI_RDATA_O <= {29'h0, bw_sel_ff};
                    OFS_CLAMP_LO: S_AXI_RDATA_O <= {20'h0, clamp_lo_ff};
                    OFS_CLAMP_HI: S_AXI_RDATA_O <= {20'h0, clamp_hi_ff};
                    OFS_STATUS:   S_AXI_RDATA_O <= {16'h0, DAC_CODE_O, ecc_corr_ff,
                                                    ecc_ff == HOFC_ECC_FATAL, ov_ff, uv_ff};
                    default: begin
                        S_AXI_RDATA_O <= '0;
                        S_AXI_RRESP_O <= RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end
endmodule

// ==== hofc_top_sva.sv ====
// hofc_top_sva: port assertions for the output filter and clamp block
// assumes one clock domain with a synchronous active-low reset
module hofc_chk
    import hofc_pkg::*;
(
    // clock and reset
    input wire logic              CLK_I,
    input wire logic              RSTN_I,
    // register bus answers
    input wire logic              S_AXI_BVALID_O,
    input wire logic              S_AXI_BREADY_I,
    input wire logic              S_AXI_RVALID_O,
    input wire logic              S_AXI_RREADY_I,
    // datapath and faults
    input wire logic              DSP_IN_STB_O,
    input wire logic              EE_LINE_ERR_I,
    input wire logic              EE_SCAN_DONE_I,
    input wire logic              SUPPLY_UV_I,
    input wire logic              SUPPLY_OV_I,
    input wire logic [CODE_W-1:0] DAC_CODE_O,
    input wire logic              DAC_STB_O
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [13:0] lp_gap_ff;
    logic [9:0]  dac_gap_ff;
    logic [4:0]  dac_n_ff;
    logic        lp_seen_ff;
    logic        dac_seen_ff;
    logic        err_d_ff;
    logic        pend_ff;
    logic        fatal_ff;

    // the first strobe after reset is not judged: its gap is unknown
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            lp_gap_ff   <= 14'h0;
            dac_gap_ff  <= 10'h0;
            dac_n_ff    <= 5'h0;
            lp_seen_ff  <= 1'b0;
            dac_seen_ff <= 1'b0;
        end else begin
            lp_gap_ff   <= DSP_IN_STB_O ? 14'h0 : lp_gap_ff + 14'h1;
            dac_gap_ff  <= DAC_STB_O ? 10'h0 : dac_gap_ff + 10'h1;
            dac_n_ff    <= (DSP_IN_STB_O ? 5'h0 : dac_n_ff) + {4'h0, DAC_STB_O};
            lp_seen_ff  <= lp_seen_ff | DSP_IN_STB_O;
            dac_seen_ff <= dac_seen_ff | DAC_STB_O;
        end
    end

    // a new faulty line while one is still pending cannot be corrected
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            err_d_ff  <= 1'b0;
            pend_ff   <= 1'b0;
            fatal_ff  <= 1'b0;
        end else begin
            err_d_ff  <= EE_LINE_ERR_I;
            if (EE_LINE_ERR_I && !err_d_ff) begin
                pend_ff  <= 1'b1;
                fatal_ff <= fatal_ff | pend_ff;
            end else if (EE_SCAN_DONE_I) begin
                pend_ff <= 1'b0;
            end
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    a_dac_period: assert property (DAC_STB_O && dac_seen_ff |-> dac_gap_ff == 10'(OUT_DIV - 1))
        else $error("dac strobe spacing wrong");
    a_lp_period: assert property (DSP_IN_STB_O && lp_seen_ff |-> lp_gap_ff == 14'(LP_DIV - 1))
        else $error("low pass strobe spacing wrong");
    a_sixteen_steps: assert property (DSP_IN_STB_O && lp_seen_ff |-> dac_n_ff inside {5'h10, 5'h11})
        else $error("dac updates per dsp result wrong");
    a_ov_level: assert property ((SUPPLY_OV_I [*8]) ##0 (DAC_STB_O && !fatal_ff) |-> DAC_CODE_O == CODE_OV)
        else $error("overvoltage level missing");
    a_uv_level: assert property (((SUPPLY_UV_I && !SUPPLY_OV_I) [*8]) ##0 (DAC_STB_O && !fatal_ff)
        |-> DAC_CODE_O == CODE_UV)
        else $error("undervoltage level missing");
    a_ee_full: assert property (DAC_STB_O && $past(fatal_ff, 8) |-> DAC_CODE_O == CODE_FULL)
        else $error("eeprom fault not at full scale");
    a_dac_hold: assert property (!DAC_STB_O |-> $stable(DAC_CODE_O))
        else $error("dac code moved off strobe");
    a_bresp_once: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write response repeated");
    a_rresp_once: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
        else $error("read response repeated");

    c_ov: cover property (SUPPLY_OV_I && DAC_STB_O);
    c_fatal: cover property (fatal_ff && DAC_STB_O);
    c_lp: cover property (DSP_IN_STB_O && lp_seen_ff);
endmodule

bind hofc_top hofc_chk u_hofc_chk (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .S_AXI_RREADY_I(S_AXI_RREADY_I), .DSP_IN_STB_O(DSP_IN_STB_O),
    .EE_LINE_ERR_I(EE_LINE_ERR_I), .EE_SCAN_DONE_I(EE_SCAN_DONE_I),
    .SUPPLY_UV_I(SUPPLY_UV_I), .SUPPLY_OV_I(SUPPLY_OV_I),
    .DAC_CODE_O(DAC_CODE_O), .DAC_STB_O(DAC_STB_O)
);

// ==== hofc_dac_model.sv ====
// hofc_dac_model: converter and reader standing at the dac code output
// assumes the code is valid in the cycle its strobe is high, 5 V supply
module hofc_dac_model
    import hofc_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    // dac sample stream
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic              stb_i,
    output logic      [CODE_W-1:0] last_code_o,
    output logic      [15:0]       mv_o
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            last_code_o <= CODE_FULL;
            mv_o        <= 16'h0;
        end else if (stb_i) begin
            last_code_o <= code_i;
            mv_o        <= 16'((32'(code_i) * 32'h1388) >> 12);
        end
    end
endmodule

// ==== hall_output_filter_clamp_tb.sv ====
// hall_output_filter_clamp_tb: register, datapath and fault tests of hofc_top
// assumes a 250 MHz clock and the dac model on the output stream
module hall_output_filter_clamp_tb import hofc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, ee_err = 1'b0, ee_done = 1'b0, uv = 1'b0, ov = 1'b0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic [15:0] hall = 16'h1234;
    logic signed [15:0] dsp_res = 16'sh8000;
    wire logic awready, wready, bvalid, arready, rvalid, dsp_stb, dac_stb;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] dsp_in, mv;
    wire logic [11:0] dac_code, last_code;
    int num_errors = 0, total_checks = 0, k;

    always #2 clk = ~clk;

    hofc_top u_hofc_top (
        .CLK_I(clk), .RSTN_I(rst_n),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .HALL_ADC_I(hall), .DSP_IN_O(dsp_in),
        .DSP_IN_STB_O(dsp_stb), .DSP_RESULT_I(dsp_res), .EE_LINE_ERR_I(ee_err),
        .EE_SCAN_DONE_I(ee_done), .SUPPLY_UV_I(uv), .SUPPLY_OV_I(ov),
        .DAC_CODE_O(dac_code), .DAC_STB_O(dac_stb)
    );
    hofc_dac_model u_hofc_dac_model (.clk_i(clk), .rstn_i(rst_n), .code_i(dac_code),
        .stb_i(dac_stb), .last_code_o(last_code), .mv_o(mv));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit aw = 1'b0, w = 1'b0;
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready && !aw) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        if (n >= 100) num_errors++;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        if (n >= 100) num_errors++;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask

    // waits for dac strobes, then one edge so the model holds the code
    task automatic dac_next(input int cnt);
        int n;
        repeat (cnt) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (!dac_stb && n < 2000);
        end
        @(posedge clk);
    endtask

    task automatic lp_next(output int dacs);
        int n = 0;
        dacs = 0;
        do begin
            @(posedge clk);
            n++;
            if (dac_stb) dacs++;
        end while (!dsp_stb && n < 20000);
    endtask

    task automatic pulse(input bit scan);
        if (scan) ee_done <= 1'b1;
        else ee_err <= 1'b1;
        repeat (8) @(posedge clk);
        ee_done <= 1'b0;
        ee_err <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(OFS_BW_SEL, 32'(RST_BW_SEL), RESP_OKAY);
        rd_chk(OFS_CLAMP_LO, 32'(RST_CLAMP_LO), RESP_OKAY);
        rd_chk(8'h14, 32'h0, RESP_SLVERR);
        wr(OFS_STATUS, 32'h0, 4'hF, RESP_SLVERR);
        wr(8'h14, 32'h0, 4'hF, RESP_SLVERR);
        // only byte lane 0 lands, bits 11:8 keep their reset value
        wr(OFS_CLAMP_HI, 32'h0000_0AB5, 4'h1, RESP_OKAY);
        rd_chk(OFS_CLAMP_HI, 32'h0000_0FB5, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_BW_SEL, 32'(i), 4'hF, RESP_OKAY);
            rd_chk(OFS_BW_SEL, 32'(i), RESP_OKAY);
        end
        // limits ordered and below the fault levels
        wr(OFS_CLAMP_LO, 32'h0000_0123, 4'hF, RESP_OKAY);
        wr(OFS_CLAMP_HI, 32'h0000_0E00, 4'hF, RESP_OKAY);
        lp_next(k);
        // from here the filter runs at its narrowest on an unchanged input
        wr(OFS_BW_SEL, 32'h0, 4'hF, RESP_OKAY);
        lp_next(k);
        chk(32'(dsp_in), 32'(hall));
        chk(32'(k == 16 || k == 17), 32'h1);
        dac_next(1);
        chk(32'(last_code), 32'h0000_0123);
        hall <= 16'h6000;
        dsp_res <= 16'sh7FF0;
        wr(OFS_BW_SEL, 32'h6, 4'hF, RESP_OKAY);
        wr(OFS_CLAMP_HI, 32'h0000_0300, 4'hF, RESP_OKAY);
        lp_next(k);
        chk(32'(dsp_in), 32'h0000_1234);
        lp_next(k);
        chk(32'(dsp_in != hall && dsp_in > 16'h1234), 32'h1);
        dac_next(1);
        chk(32'(last_code), 32'h0000_0300);
        wr(OFS_CLAMP_LO, 32'h0000_0600, 4'hF, RESP_OKAY);
        wr(OFS_CLAMP_HI, 32'h0000_0200, 4'hF, RESP_OKAY);
        dac_next(2);
        chk(32'(last_code), 32'h0000_0200);
        uv <= 1'b1;
        dac_next(2);
        chk(32'(last_code), 32'(CODE_UV));
        rd_chk(OFS_STATUS, {16'h0, CODE_UV, 4'h1}, RESP_OKAY);
        ov <= 1'b1;
        dac_next(2);
        chk(32'(last_code), 32'(CODE_OV));
        uv <= 1'b0;
        ov <= 1'b0;
        dac_next(2);
        chk(32'(last_code), 32'h0000_0200);
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b0);
        dac_next(2);
        chk(32'(last_code), 32'h0000_0200);
        pulse(1'b0);
        uv <= 1'b1;
        dac_next(2);
        chk(32'(last_code), 32'(CODE_FULL));
        uv <= 1'b0;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk(32'(dac_code), 32'(CODE_FULL));
        wr(OFS_CLAMP_LO, 32'h0000_0555, 4'hF, RESP_OKAY);
        wr(OFS_CLAMP_HI, 32'h0000_0555, 4'hF, RESP_OKAY);
        dac_next(2);
        chk(32'(last_code), 32'h0000_0555);
        chk(32'(mv), 32'h0000_0682);
        tally_and_finish;
    end
endmodule
